// ==== src/gpio_lookup_table_logic.v ====
// lookup-table decode logic of the expander's gpio banks
// Behaviour
// - bank a low 2-to-1: pin 2 = low table nibble bit indexed by pins 1:0.
// - bank b high 3-to-1: pin 15 = table 0x24 bit indexed by pins 14:12.
// - bank a high 3-to-1: pin 7 = table 0x25 bit indexed by pins 6:4.
// - bank b low 3-to-1: pin 11 = table 0x26 bit indexed by pins 10:8.
// - bank a low 3-to-1: pin 3 = table 0x27 bit indexed by pins 2:0.
// - bank a low mode: 00 gpio, 01 2-to-1, 10 3-to-1, 11 no decode.
// - bank a high mode: 00 gpio, 01 no decode, 10 3-to-1, 11 reserved.
// - bank b low mode: 00 gpio, 01 no decode, 10 3-to-1, 11 no decode.
// - bank b high mode: 01 no decode, 10 3-to-1 pin 15, 11 reserved.
`timescale 1ns/100ps
`default_nettype none
`include "lut_defs.vh"
module gpio_lookup_table_logic (
  input  wire        mclk_i,
  input  wire        reset_i,
  input  wire        reg_wr_i,
  input  wire [7:0]  reg_addr_i,
  input  wire [7:0]  reg_wdata_i,
  output reg  [7:0]  reg_rdata_o,
  input  wire [1:0]  bank_a_low_decode_select_i,
  input  wire [1:0]  bank_a_high_decode_select_i,
  input  wire [1:0]  bank_b_low_decode_select_i,
  input  wire [1:0]  bank_b_high_decode_select_i,
  input  wire [3:0]  bank_a_two_input_table_i,
  input  wire [15:0] pin_i,
  output wire [15:0] lut_out_o,
  output wire [15:0] lut_drive_o
);
  reg  [7:0]  bank_b_high_three_input_table_r;
  reg  [7:0]  bank_a_high_three_input_table_r;
  reg  [7:0]  bank_b_low_three_input_table_r;
  reg  [7:0]  bank_a_low_three_input_table_r;
  reg  [15:0] pin_meta_r;
  reg  [15:0] pin_sync_r;
  wire [4:0]  val;
  wire [4:0]  en;
  wire [39:0] tables;
  wire [14:0] idx;
  wire [4:0]  sel;

  // pins pass two flops; decode is combinational from the synchronised level
  always @(posedge mclk_i) begin
    if (reset_i) begin
      pin_meta_r <= 16'h0000;
      pin_sync_r <= 16'h0000;
    end else begin
      pin_meta_r <= pin_i;
      pin_sync_r <= pin_meta_r;
    end
  end

  always @(posedge mclk_i) begin
    if (reset_i) begin
      bank_b_high_three_input_table_r <= `TABLE_RESET;
      bank_a_high_three_input_table_r <= `TABLE_RESET;
      bank_b_low_three_input_table_r  <= `TABLE_RESET;
      bank_a_low_three_input_table_r  <= `TABLE_RESET;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `ADDR_BANK_B_HIGH_THREE_INPUT_TABLE: bank_b_high_three_input_table_r <= reg_wdata_i;
        `ADDR_BANK_A_HIGH_THREE_INPUT_TABLE: bank_a_high_three_input_table_r <= reg_wdata_i;
        `ADDR_BANK_B_LOW_THREE_INPUT_TABLE:  bank_b_low_three_input_table_r  <= reg_wdata_i;
        `ADDR_BANK_A_LOW_THREE_INPUT_TABLE:  bank_a_low_three_input_table_r  <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  always @(posedge mclk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      case (reg_addr_i)
        `ADDR_BANK_B_HIGH_THREE_INPUT_TABLE: reg_rdata_o <= bank_b_high_three_input_table_r;
        `ADDR_BANK_A_HIGH_THREE_INPUT_TABLE: reg_rdata_o <= bank_a_high_three_input_table_r;
        `ADDR_BANK_B_LOW_THREE_INPUT_TABLE:  reg_rdata_o <= bank_b_low_three_input_table_r;
        `ADDR_BANK_A_LOW_THREE_INPUT_TABLE:  reg_rdata_o <= bank_a_low_three_input_table_r;
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // slot 0: two-input table, upper bits unused so index bit 2 is held low
  assign tables = {bank_b_high_three_input_table_r,
                   bank_a_high_three_input_table_r,
                   bank_b_low_three_input_table_r,
                   bank_a_low_three_input_table_r,
                   4'h0, bank_a_two_input_table_i};
  assign idx = {pin_sync_r[14:12], pin_sync_r[6:4], pin_sync_r[10:8],
                pin_sync_r[2:0], 1'b0, pin_sync_r[1:0]};
  assign sel[0] = (bank_a_low_decode_select_i == `MODE_TWO_TO_ONE);
  assign sel[1] = (bank_a_low_decode_select_i == `MODE_THREE_TO_ONE);
  assign sel[2] = (bank_b_low_decode_select_i == `MODE_THREE_TO_ONE);
  assign sel[3] = (bank_a_high_decode_select_i == `MODE_THREE_TO_ONE);
  assign sel[4] = (bank_b_high_decode_select_i == `MODE_THREE_TO_ONE);

  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_lut
      lut_select u_lut (
        .table_i  (tables[g*8 +: 8]),
        .index_i  (idx[g*3 +: 3]),
        .enable_i (sel[g]),
        .value_o  (val[g]),
        .enable_o (en[g])
      );
    end
  endgenerate

  // other pins stay with normal gpio; table has no effect unless selected
  // bit order: 15 bank b high, 11 bank b low, 7 bank a high, 3 and 2 bank a low
  assign lut_out_o = {val[4] & en[4], 3'h0, val[2] & en[2], 3'h0,
                      val[3] & en[3], 3'h0, val[1] & en[1], val[0] & en[0], 2'h0};
  assign lut_drive_o = {en[4], 3'h0, en[2], 3'h0, en[3], 3'h0, en[1], en[0], 2'h0};
endmodule // gpio_lookup_table_logic
`default_nettype wire

// ==== src/lut_defs.vh ====
// register offsets, field positions and mode codes of the lookup-table logic
`ifndef LUT_DEFS_VH
`define LUT_DEFS_VH
`define ADDR_BANK_B_HIGH_THREE_INPUT_TABLE 8'h24
`define ADDR_BANK_A_HIGH_THREE_INPUT_TABLE 8'h25
`define ADDR_BANK_B_LOW_THREE_INPUT_TABLE  8'h26
`define ADDR_BANK_A_LOW_THREE_INPUT_TABLE  8'h27
`define TABLE_RESET                        8'h00
`define MODE_RESET                         2'h0
`define MODE_GPIO                          2'h0
`define MODE_TWO_TO_ONE                    2'h1
`define MODE_THREE_TO_ONE                  2'h2
`define MODE_THREE_TO_TWO                  2'h3
`define PIN_A_LOW_TWO_OUT                  2
`define PIN_A_LOW_THREE_OUT                3
`define PIN_A_HIGH_THREE_OUT               7
`define PIN_B_LOW_THREE_OUT                11
`define PIN_B_HIGH_THREE_OUT               15
`endif

// ==== src/lut_select.v ====
// one truth-table lookup: index picks a table bit; mode match passes through ungated as enable
`timescale 1ns/100ps
`default_nettype none
module lut_select (
  input  wire [7:0] table_i,
  input  wire [2:0] index_i,
  input  wire       enable_i,
  output wire       value_o,
  output wire       enable_o
);
  // purely combinational so table writes and pin changes show at once
  assign value_o  = table_i[index_i];
  assign enable_o = enable_i;
endmodule // lut_select
`default_nettype wire

// ==== verification/host_model.sv ====
// host model: table register writes and readback
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic       mclk_i,
  input  wire logic [7:0] rdata_i,
  output var  logic       wr_o,
  output var  logic [7:0] addr_o,
  output var  logic [7:0] wdata_o
);
  initial {wr_o, addr_o, wdata_o} = 17'h00000;
  // data inverted after release so a stale bus never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i) {wr_o, addr_o, wdata_o} <= {1'b1, a, d};
    @(posedge mclk_i) {wr_o, wdata_o} <= {1'b0, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i) addr_o <= a;
    @(posedge mclk_i) #1 d = rdata_i;
  endtask
endmodule // host_model
`default_nettype wire

// ==== verification/gpio_lookup_table_logic_sva.sv ====
// decode output assertions
`timescale 1ns/100ps
`default_nettype none
module lut_chk (
  input wire logic        mclk_i, reset_i, reg_wr_i,
  input wire logic [7:0]  reg_addr_i, reg_wdata_i,
  input wire logic [1:0]  bank_a_low_decode_select_i, bank_a_high_decode_select_i,
  input wire logic [1:0]  bank_b_low_decode_select_i, bank_b_high_decode_select_i,
  input wire logic [3:0]  bank_a_two_input_table_i,
  input wire logic [15:0] pin_i, lut_out_o, lut_drive_o
);
  wire [1:0] al = bank_a_low_decode_select_i, ah = bank_a_high_decode_select_i;
  wire [1:0] bl = bank_b_low_decode_select_i, bh = bank_b_high_decode_select_i;
  logic [15:0] p1, p2;
  logic [7:0]  t [4];
  // pins reach the decode two flops late
  always_ff @(posedge mclk_i) begin
    p1 <= reset_i ? 16'h0000 : pin_i;
    p2 <= reset_i ? 16'h0000 : p1;
    if (reset_i) t <= '{default: 8'h00};
    else if (reg_wr_i && reg_addr_i[7:2] == 6'h09) t[reg_addr_i[1:0]] <= reg_wdata_i;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  AST_A_LOW_TWO: assert property (al == 2'h1 |->
    lut_out_o[2] == bank_a_two_input_table_i[p2[1:0]]) else $error("pin 2 decode");
  AST_B_HIGH: assert property (bh == 2'h2 |->
    lut_out_o[15] == t[0][p2[14:12]]) else $error("pin 15 decode");
  AST_A_HIGH: assert property (ah == 2'h2 |->
    lut_out_o[7] == t[1][p2[6:4]]) else $error("pin 7 decode");
  AST_B_LOW: assert property (bl == 2'h2 |->
    lut_out_o[11] == t[2][p2[10:8]]) else $error("pin 11 decode");
  AST_A_LOW: assert property (al == 2'h2 |->
    lut_out_o[3] == t[3][p2[2:0]]) else $error("pin 3 decode");
  AST_GATED: assert property ((lut_out_o & ~lut_drive_o) == 16'h0000 &&
    (lut_drive_o & 16'h7773) == 16'h0000) else $error("stray decode");
  AST_A_LOW_DRV: assert property (lut_drive_o[3:2] == {al == 2'h2, al == 2'h1})
    else $error("bank a low drive");
  AST_DRV: assert property ({lut_drive_o[15], lut_drive_o[11], lut_drive_o[7]} ==
    {bh == 2'h2, bl == 2'h2, ah == 2'h2}) else $error("three-input drive");
endmodule // lut_chk
bind gpio_lookup_table_logic lut_chk CHK (.*);
`default_nettype wire

// ==== verification/gpio_lookup_table_logic_tb.sv ====
// self-checking bench of the decode logic
`timescale 1ns/100ps
`default_nettype none
module gpio_lookup_table_logic_tb;
  logic mclk_i, reset_i, wr;
  logic [7:0] addr, wdata, rdata, d;
  logic [1:0] md;
  logic [3:0] tab2;
  logic [15:0] pin, out, drv, e;
  logic [7:0] tv [4] = '{8'hA5, 8'h3C, 8'h96, 8'h81};
  int bad_count = 0, check_count = 0;
  host_model HOST (.mclk_i(mclk_i), .rdata_i(rdata), .wr_o(wr), .addr_o(addr), .wdata_o(wdata));
  gpio_lookup_table_logic DUT (.mclk_i(mclk_i), .reset_i(reset_i), .reg_wr_i(wr),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .bank_a_low_decode_select_i(md), .bank_a_high_decode_select_i(md),
    .bank_b_low_decode_select_i(md), .bank_b_high_decode_select_i(md),
    .bank_a_two_input_table_i(tab2), .pin_i(pin), .lut_out_o(out), .lut_drive_o(drv));
  initial begin
    mclk_i = 0;
    forever #5 mclk_i = ~mclk_i;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    check_count++;
    if (g !== x) begin
      bad_count++;
      $display("Error %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    {reset_i, md, tab2, pin} = {1'b1, 2'h0, 4'hA, 16'h0000};
    repeat (20) @(posedge mclk_i);
    reset_i <= 0;
    HOST.wr(8'h28, 8'hFF); // unmapped, must stay invisible
    for (int k = 0; k < 2; k++) begin
      for (int a = 0; a < 5; a++) begin
        HOST.rd(8'(36 + a), d);
        chk({8'h00, d}, {8'h00, (k && a < 4) ? tv[a] : 8'h00});
      end
      for (int a = 0; a < 4; a++) HOST.wr(8'(36 + a), tv[a]);
    end
    // every mode code against every index
    for (int m = 0; m < 4; m++) for (int i = 0; i < 8; i++) begin
      @(posedge mclk_i) {md, pin} <= {m[1:0], {4{1'b0, i[2:0]}}};
      repeat (3) @(posedge mclk_i);
      #1 e = 16'h0000;
      if (m == 2) e = {tv[0][i], 3'h0, tv[2][i], 3'h0, tv[1][i], 3'h0, tv[3][i], 3'h0};
      if (m == 1) e[2] = tab2[i[1:0]];
      chk(out, e);
      chk(drv, m == 2 ? 16'h8888 : m == 1 ? 16'h0004 : 16'h0000);
    end
    @(posedge mclk_i) md <= 2'h2;
    HOST.wr(8'h27, 8'h7E);
    #1 chk({15'h0000, out[3]}, 16'h0000);
    report_and_stop();
  end
endmodule // gpio_lookup_table_logic_tb
`default_nettype wire
